/* File: logic/period_timer.sv */
// free-running period counter giving one pulse per period
// assumes a single clock and synchronous clear
`timescale 1ns/1ps
`default_nettype none
module period_timer #(
  parameter int WIDTH = 40,
  parameter logic [WIDTH-1:0] PERIOD = 40'd100
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  output logic tick
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r + 1'b1;
    if (clear || count_r == PERIOD - 1'b1) begin
      count_nxt = '0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign tick = !clear && (count_r == PERIOD - 1'b1);
endmodule
`default_nettype wire

/* File: logic/servo_autotune_param_control.sv */
// parameter management while real-time auto-gain tuning runs
// assumes a synchronous register port, a nonvolatile store port and a tuner outside
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "autotune_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module servo_autotune_param_control
  import autotune_pkg::*;
#(
  parameter logic [39:0] SAVE_CYCLES = 40'(`SAVE_CYCLES)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  output logic write_rejected,
  input wire logic power_on_pulse,
  input wire tuned_pair_type nv_load_data,
  input wire logic nv_load_valid,
  output tuned_pair_type nv_store_data,
  output logic nv_store_req,
  input wire logic nv_store_done,
  input wire tuned_pair_type tuner_estimate,
  input wire logic tuner_estimate_valid,
  input wire logic torque_control_active,
  input wire logic position_control_active,
  input wire logic trial_run_active,
  input wire logic ccw_limit_switch_input,
  input wire logic cw_limit_switch_input,
  input wire logic gain_limit_select_input,
  input wire logic [15:0] ccw_analog_limit_input,
  input wire logic [15:0] cw_analog_limit_input,
  output logic tuning_enable,
  output logic adaptive_filter_enable,
  output logic inertia_estimate_enable,
  output logic estimate_reset,
  output logic [15:0] active_notch_freq,
  output logic speed_observer_enable,
  output logic ccw_motion_inhibit,
  output logic cw_motion_inhibit,
  output logic travel_inhibit_fault,
  output logic [15:0] ccw_limit_out,
  output logic [15:0] cw_limit_out
);
  // ============================================================
  // parameter storage
  logic [15:0] param_r [0:255];
  logic [15:0] param_nxt [0:255];
  logic [1:0] travel_active_r;
  logic [1:0] travel_active_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rej_r;
  logic rej_nxt;
  logic both_zero_r;
  logic both_zero_nxt;
  logic est_reset_r;
  logic est_reset_nxt;
  logic [15:0] held_notch_r;
  logic [15:0] held_notch_nxt;
  logic tuning_on;
  logic filt_on;
  logic locked_addr;
  logic tick;
  logic [7:0] a;

  assign a = reg_req.addr;
  assign tuning_on = param_r[`IDX_TUNE_MODE] >= 16'h0001
    && param_r[`IDX_TUNE_MODE] <= 16'h0007;
  assign filt_on = param_r[`IDX_FILT_MODE] != 16'h0000;
  // lock set of tuner-adjusted parameters
  assign locked_addr = (a >= `IDX_GAIN_LO && a <= `IDX_GAIN_HI && a != `IDX_FF_GAIN
    && a != `IDX_FF_FILT && a != 8'h15 + 8'h02 && a != 8'h18 - 8'h01)
    || a == `IDX_INERTIA || a == `IDX_NOTCH_FREQ;

  // ============================================================
  // parameter write, forcing and read
  always_comb begin
    logic zero_now;
    zero_now = 1'b0;
    for (int i = 0; i < 256; i++) begin
      param_nxt[i] = param_r[i];
    end
    travel_active_nxt = travel_active_r;
    rej_nxt = 1'b0;
    est_reset_nxt = 1'b0;
    if (reg_req.wr) begin
      if (tuning_on && locked_addr) begin
        rej_nxt = 1'b1;
      end else if (a == `IDX_TORQUE_SEL && reg_req.wdata > 16'h0003) begin
        rej_nxt = 1'b1;
      end else if (a == `IDX_TRAVEL_INH && reg_req.wdata > 16'h0002) begin
        rej_nxt = 1'b1;
      end else if (a == `IDX_TUNE_MODE && reg_req.wdata > 16'h0007) begin
        rej_nxt = 1'b1;
      end else begin
        param_nxt[a] = reg_req.wdata;
      end
    end
    // tuner results land in the locked parameters
    if (tuner_estimate_valid && tuning_on) begin
      param_nxt[`IDX_INERTIA] = tuner_estimate.inertia;
      param_nxt[`IDX_NOTCH_FREQ] = tuner_estimate.notch;
    end
    // restore last saved pair at power-up
    if (nv_load_valid) begin
      param_nxt[`IDX_INERTIA] = nv_load_data.inertia;
      param_nxt[`IDX_NOTCH_FREQ] = nv_load_data.notch;
    end
    // power-cycle parameter takes effect only here
    if (power_on_pulse) begin
      travel_active_nxt = param_r[`IDX_TRAVEL_INH][1:0];
    end
    if (tuning_on) begin
      param_nxt[`IDX_FF_GAIN] = `FF_GAIN_FORCE;
      param_nxt[`IDX_FF_FILT] = `FF_FILT_FORCE;
      param_nxt[`IDX_OBSERVER] = 16'h0000;
      param_nxt[`IDX_SW_SETUP] = `SW_SETUP_FORCE;
      param_nxt[`IDX_SW_DELAY] = `SW_DELAY_FORCE;
      param_nxt[`IDX_SW_LEVEL] = `SW_LEVEL_FORCE;
      param_nxt[`IDX_SW_HYST] = `SW_HYST_FORCE;
      param_nxt[`IDX_PG_TIME] = `PG_TIME_FORCE;
      param_nxt[`IDX_SW_MODE2] = 16'h0000;
      if (position_control_active && param_r[`IDX_TUNE_MODE] <= 16'h0006) begin
        param_nxt[`IDX_SW_MODE1] = `SW_MODE1_POS;
      end else begin
        param_nxt[`IDX_SW_MODE1] = 16'h0000;
      end
    end
    // both modes at zero arms a reset of estimation on re-enable
    zero_now = param_r[`IDX_TUNE_MODE] == 16'h0000 && !filt_on;
    both_zero_nxt = both_zero_r;
    if (zero_now) begin
      both_zero_nxt = 1'b1;
    end else if (both_zero_r && tuning_on && filt_on) begin
      both_zero_nxt = 1'b0;
      est_reset_nxt = 1'b1;
    end
    rdata_nxt = 16'h0000;
    if (reg_req.rd) begin
      if (a == `IDX_STATUS) begin
        rdata_nxt = {11'h000, nv_store_req, travel_active_r, filt_on, tuning_on};
      end else begin
        rdata_nxt = param_r[a];
      end
    end
    // hold the notch frequency in use across a torque switch in modes 4/5
    held_notch_nxt = held_notch_r;
    if (!torque_control_active) begin
      held_notch_nxt = param_r[`IDX_NOTCH_FREQ];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        param_r[i] <= 16'h0000;
      end
      param_r[`IDX_TUNE_MODE] <= `TUNE_MODE_RST;
      param_r[`IDX_TORQUE_SEL] <= `TORQUE_SEL_RST;
      param_r[`IDX_TRAVEL_INH] <= `TRAVEL_INH_RST;
      travel_active_r <= 2'(`TRAVEL_INH_RST);
      rdata_r <= 16'h0000;
      rej_r <= 1'b0;
      both_zero_r <= 1'b0;
      est_reset_r <= 1'b0;
      held_notch_r <= 16'h0000;
    end else begin
      for (int i = 0; i < 256; i++) begin
        param_r[i] <= param_nxt[i];
      end
      travel_active_r <= travel_active_nxt;
      rdata_r <= rdata_nxt;
      rej_r <= rej_nxt;
      both_zero_r <= both_zero_nxt;
      est_reset_r <= est_reset_nxt;
      held_notch_r <= held_notch_nxt;
    end
  end

  // ============================================================
  // periodic save of the tuned pair
  nv_state_type nv_state_r;
  nv_state_type nv_state_nxt;
  tuned_pair_type store_r;
  tuned_pair_type store_nxt;

  period_timer #(
    .WIDTH(40),
    .PERIOD(SAVE_CYCLES)
  ) u_save_timer (
    .mclk(mclk),
    .reset(reset),
    .clear(!tuning_on),
    .tick(tick)
  );

  always_comb begin
    nv_state_nxt = nv_state_r;
    store_nxt = store_r;
    case (nv_state_r)
      st_boot: begin
        nv_state_nxt = st_run;
      end
      st_run: begin
        if (tick) begin
          store_nxt.inertia = param_r[`IDX_INERTIA];
          store_nxt.notch = param_r[`IDX_NOTCH_FREQ];
          nv_state_nxt = st_save;
        end
      end
      st_save: begin
        // a tick during a slow store is dropped; the next period catches up
        if (nv_store_done) begin
          nv_state_nxt = st_run;
        end
      end
      default: begin
        nv_state_nxt = st_boot;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nv_state_r <= st_boot;
      store_r <= '0;
    end else begin
      nv_state_r <= nv_state_nxt;
      store_r <= store_nxt;
    end
  end

  // ============================================================
  // torque limits
  torque_limit_mux u_limit_mux (
    .mclk(mclk),
    .reset(reset),
    .torque_limit_select(param_r[`IDX_TORQUE_SEL][1:0]),
    .first_torque_limit(param_r[`IDX_LIMIT1]),
    .second_torque_limit(param_r[`IDX_LIMIT2]),
    .ccw_analog_limit_input(ccw_analog_limit_input),
    .cw_analog_limit_input(cw_analog_limit_input),
    .gain_limit_select_input(gain_limit_select_input),
    .ccw_limit_out(ccw_limit_out),
    .cw_limit_out(cw_limit_out)
  );

  // ============================================================
  // outputs
  assign reg_rdata = rdata_r;
  assign write_rejected = rej_r;
  assign nv_store_data = store_r;
  assign nv_store_req = nv_state_r == st_save;
  assign tuning_enable = tuning_on;
  assign adaptive_filter_enable = filt_on && !torque_control_active;
  assign active_notch_freq = (torque_control_active && (param_r[`IDX_CONTROL_MODE] == 16'h0004
    || param_r[`IDX_CONTROL_MODE] == 16'h0005)) ? held_notch_r : param_r[`IDX_NOTCH_FREQ];
  assign inertia_estimate_enable = tuning_on && !trial_run_active;
  assign estimate_reset = est_reset_r;
  assign speed_observer_enable = !tuning_on
    && param_r[`IDX_OBSERVER] != 16'h0000;
  // switch input high means contact open, i.e. limit activated
  assign ccw_motion_inhibit = travel_active_r != 2'h1 && ccw_limit_switch_input;
  assign cw_motion_inhibit = travel_active_r != 2'h1 && cw_limit_switch_input;
  assign travel_inhibit_fault = travel_active_r == 2'h2
    && (ccw_limit_switch_input || cw_limit_switch_input);
endmodule
`default_nettype wire

/* File: logic/torque_limit_mux.sv */
// torque limit source selection per direction
// assumes the selector already holds a legal value
`timescale 1ns/1ps
`default_nettype none
module torque_limit_mux (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] torque_limit_select,
  input wire logic [15:0] first_torque_limit,
  input wire logic [15:0] second_torque_limit,
  input wire logic [15:0] ccw_analog_limit_input,
  input wire logic [15:0] cw_analog_limit_input,
  input wire logic gain_limit_select_input,
  output logic [15:0] ccw_limit_out,
  output logic [15:0] cw_limit_out
);
  logic [15:0] ccw_r;
  logic [15:0] ccw_nxt;
  logic [15:0] cw_r;
  logic [15:0] cw_nxt;

  always_comb begin
    case (torque_limit_select)
      2'h0: begin
        ccw_nxt = ccw_analog_limit_input;
        cw_nxt = cw_analog_limit_input;
      end
      2'h1: begin
        ccw_nxt = first_torque_limit;
        cw_nxt = first_torque_limit;
      end
      2'h2: begin
        ccw_nxt = first_torque_limit;
        cw_nxt = second_torque_limit;
      end
      default: begin
        // input high means shorted
        ccw_nxt = gain_limit_select_input ? second_torque_limit : first_torque_limit;
        cw_nxt = ccw_nxt;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ccw_r <= 16'h0000;
      cw_r <= 16'h0000;
    end else begin
      ccw_r <= ccw_nxt;
      cw_r <= cw_nxt;
    end
  end

  assign ccw_limit_out = ccw_r;
  assign cw_limit_out = cw_r;
endmodule
`default_nettype wire

/* File: pkg/autotune_defs.svh */
// constants for the auto-tune parameter control block
// assumes one clock domain, a plain register port and 16-bit parameter words
//
// Functional notes
// - tuning runs for mode 1..7, default 1
// - adaptive notch enabled when filter mode nonzero
// - tuned parameters write-locked while tuning
// - force feed-forward 300, filter 50, observer 0
// - force switching set 1,30,50,33,20,0
// - switch mode 10 in position, mode 1..6
// - both modes zero then nonzero resets estimates
// - filter mode zero disables adaptive filter
// - save inertia and notch every 30 minutes
// - power-up restores last saved values
// - tuning disables instantaneous speed observer
// - torque control disables filter, modes 4/5 hold
// - external trial run suspends inertia estimation
// - power-cycle parameters apply after next power-on
// - torque limit source select 0..3, default 1
// - over-travel inhibit setup 0..2, power-cycle
`ifndef AUTOTUNE_DEFS_SVH
`define AUTOTUNE_DEFS_SVH

// ============================================================
// parameter indices (word addresses of the register port)
`define IDX_CONTROL_MODE 8'h02
`define IDX_TORQUE_SEL 8'h03
`define IDX_TRAVEL_INH 8'h04
`define IDX_GAIN_LO 8'h10
`define IDX_GAIN_HI 8'h1C
`define IDX_FF_GAIN 8'h15
`define IDX_FF_FILT 8'h16
`define IDX_INERTIA 8'h20
`define IDX_TUNE_MODE 8'h21
`define IDX_STIFFNESS 8'h22
`define IDX_FILT_MODE 8'h23
`define IDX_OBSERVER 8'h27
`define IDX_NOTCH_FREQ 8'h2F
`define IDX_SW_SETUP 8'h30
`define IDX_SW_MODE1 8'h31
`define IDX_SW_DELAY 8'h32
`define IDX_SW_LEVEL 8'h33
`define IDX_SW_HYST 8'h34
`define IDX_PG_TIME 8'h35
`define IDX_SW_MODE2 8'h36
`define IDX_LIMIT1 8'h5E
`define IDX_LIMIT2 8'h5F
`define IDX_STATUS 8'hF0

// ============================================================
// reset values and forced values
`define TUNE_MODE_RST 16'h0001
`define TORQUE_SEL_RST 16'h0001
`define TRAVEL_INH_RST 16'h0001
`define FF_GAIN_FORCE 16'h012C
`define FF_FILT_FORCE 16'h0032
`define SW_SETUP_FORCE 16'h0001
`define SW_MODE1_POS 16'h000A
`define SW_DELAY_FORCE 16'h001E
`define SW_LEVEL_FORCE 16'h0032
`define SW_HYST_FORCE 16'h0021
`define PG_TIME_FORCE 16'h0014

// ============================================================
// timing: save period in minutes at a 40 MHz clock
`define SAVE_PERIOD_MIN 30
`define CLK_HZ 40000000
`define SAVE_CYCLES (64'd60 * `SAVE_PERIOD_MIN * `CLK_HZ)

`endif

/* File: pkg/autotune_pkg.sv */
// types for the auto-tune parameter control block
// assumes autotune_defs.svh for the numeric constants
package autotune_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] inertia;
    logic [15:0] notch;
  } tuned_pair_type;

  typedef enum logic [1:0] {
    st_boot = 2'b00,
    st_run = 2'b01,
    st_save = 2'b10
  } nv_state_type;
endpackage

/* File: testbench/autotune_sva.sv */
// port checker for the auto-tune parameter control block
// assumes one clock domain, reset asynchronous active high
`include "autotune_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module autotune_sva
  import autotune_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire reg_req_type reg_req,
  input wire logic write_rejected,
  input wire logic tuning_enable,
  input wire logic speed_observer_enable,
  input wire logic adaptive_filter_enable,
  input wire logic torque_control_active,
  input wire logic trial_run_active,
  input wire logic inertia_estimate_enable,
  input wire logic nv_store_req,
  input wire logic nv_store_done,
  input wire tuned_pair_type nv_store_data,
  input wire logic estimate_reset,
  input wire logic ccw_motion_inhibit,
  input wire logic ccw_limit_switch_input
);
  // ============================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_wait;
    nv_store_req && !nv_store_done;
  endsequence
  property p_lock;
    reg_req.wr && tuning_enable && reg_req.addr inside {`IDX_INERTIA, `IDX_NOTCH_FREQ,
      [`IDX_GAIN_LO:8'h14], [8'h18:`IDX_GAIN_HI]} |=> write_rejected;
  endproperty
  property p_free;
    reg_req.wr && !tuning_enable && reg_req.addr == `IDX_INERTIA |=> !write_rejected;
  endproperty
  property p_obs;
    tuning_enable |-> !speed_observer_enable;
  endproperty
  property p_torq;
    torque_control_active |-> !adaptive_filter_enable;
  endproperty
  property p_trial;
    trial_run_active |-> !inertia_estimate_enable;
  endproperty
  property p_sel;
    reg_req.wr && reg_req.addr == `IDX_TORQUE_SEL && reg_req.wdata > 16'h0003
      |=> write_rejected;
  endproperty
  property p_trav;
    reg_req.wr && reg_req.addr == `IDX_TRAVEL_INH && reg_req.wdata > 16'h0002
      |=> write_rejected;
  endproperty
  property p_store;
    s_wait |=> nv_store_req && $stable(nv_store_data);
  endproperty
  property p_est;
    estimate_reset |-> tuning_enable ##1 !estimate_reset;
  endproperty
  property p_inh;
    ccw_motion_inhibit |-> ccw_limit_switch_input;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted");
  a_free: assert property (p_free) else $error("free write refused");
  a_obs: assert property (p_obs) else $error("observer on while tuning");
  a_torq: assert property (p_torq) else $error("filter on in torque");
  a_trial: assert property (p_trial) else $error("estimate during trial");
  a_sel: assert property (p_sel) else $error("limit select range");
  a_trav: assert property (p_trav) else $error("travel setup range");
  a_store: assert property (p_store) else $error("store request dropped");
  a_est: assert property (p_est) else $error("estimate reset pulse");
  a_inh: assert property (p_inh) else $error("inhibit without switch");
endmodule
bind servo_autotune_param_control autotune_sva autotune_sva_i (.mclk(mclk), .reset(reset),
  .reg_req(reg_req), .write_rejected(write_rejected), .tuning_enable(tuning_enable),
  .speed_observer_enable(speed_observer_enable), .nv_store_data(nv_store_data),
  .adaptive_filter_enable(adaptive_filter_enable), .trial_run_active(trial_run_active),
  .torque_control_active(torque_control_active), .nv_store_done(nv_store_done),
  .inertia_estimate_enable(inertia_estimate_enable), .nv_store_req(nv_store_req),
  .estimate_reset(estimate_reset), .ccw_motion_inhibit(ccw_motion_inhibit),
  .ccw_limit_switch_input(ccw_limit_switch_input));
`default_nettype wire

/* File: testbench/nv_model.sv */
// nonvolatile store model holding the saved inertia and notch pair
// assumes nv_store_req stays high until nv_store_done
`timescale 1ns/1ps
`default_nettype none
module nv_model
  import autotune_pkg::*;
(
  input wire logic mclk,
  input wire logic power_on_pulse,
  input wire logic nv_store_req,
  input wire tuned_pair_type nv_store_data,
  input wire logic [3:0] lat,
  output tuned_pair_type nv_load_data,
  output logic nv_load_valid,
  output logic nv_store_done,
  output var int saves,
  output tuned_pair_type stored
);
  int cnt = 0;
  int ld = 0;
  // ============================================================
  // store contents survive reset, so the model has no reset
  initial begin
    stored = {16'h0123, 16'h0456};
    saves = 0;
    nv_load_valid = 1'b0;
    nv_store_done = 1'b0;
  end
  // idle data is inverted so a stale sample cannot match
  assign nv_load_data = nv_load_valid ? stored : ~stored;
  always @(posedge mclk) begin
    ld <= power_on_pulse ? 2 : (ld > 0 ? ld - 1 : 0);
    nv_load_valid <= (ld == 1);
    nv_store_done <= 1'b0;
    if (nv_store_req && !nv_store_done) begin
      cnt <= cnt + 1;
      if (cnt >= int'(lat)) begin
        nv_store_done <= 1'b1;
        stored <= nv_store_data;
        saves <= saves + 1;
        cnt <= 0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/servo_autotune_param_control_tb.sv */
// self-checking bench for the auto-tune parameter control block
// assumes nv_model as the store and the bench acting as tuner and host
`include "autotune_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module servo_autotune_param_control_tb
  import autotune_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic pon = 1'b0;
  logic est_v = 1'b0;
  logic torq = 1'b0, posc = 1'b0, trial = 1'b0, ccw_sw = 1'b0, cw_sw = 1'b0, gsel = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [15:0] ccw_an = 16'h0333, cw_an = 16'h0444;
  logic [15:0] rdata, notch, ccw_lim, cw_lim;
  logic rej, ld_v, st_req, st_done, tun_en, af_en, ie_en, est_rst, obs_en, ccw_inh, cw_inh, fault;
  reg_req_type req = '0;
  tuned_pair_type est = '0, ld, st, stored;
  int saves, fails = 0, total_checks = 0;
  logic [7:0] fa [9] = '{`IDX_FF_GAIN, `IDX_FF_FILT, `IDX_OBSERVER, `IDX_SW_SETUP,
    `IDX_SW_DELAY, `IDX_SW_LEVEL, `IDX_SW_HYST, `IDX_PG_TIME, `IDX_SW_MODE2};
  logic [15:0] fv [9] = '{`FF_GAIN_FORCE, `FF_FILT_FORCE, 16'h0000, `SW_SETUP_FORCE,
    `SW_DELAY_FORCE, `SW_LEVEL_FORCE, `SW_HYST_FORCE, `PG_TIME_FORCE, 16'h0000};
  logic [15:0] lt [5][4] = '{'{0, 0, 16'h0333, 16'h0444}, '{1, 0, 16'h0111, 16'h0111},
    '{2, 0, 16'h0111, 16'h0222}, '{3, 0, 16'h0111, 16'h0111}, '{3, 1, 16'h0222, 16'h0222}};
  always #12.5 mclk = ~mclk;
  servo_autotune_param_control #(.SAVE_CYCLES(40'd20)) servo_autotune_param_control_i (
    .mclk(mclk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .write_rejected(rej),
    .power_on_pulse(pon), .nv_load_data(ld), .nv_load_valid(ld_v), .nv_store_data(st),
    .nv_store_req(st_req), .nv_store_done(st_done), .tuner_estimate(est),
    .tuner_estimate_valid(est_v), .torque_control_active(torq),
    .position_control_active(posc), .trial_run_active(trial),
    .ccw_limit_switch_input(ccw_sw), .cw_limit_switch_input(cw_sw),
    .gain_limit_select_input(gsel), .ccw_analog_limit_input(ccw_an),
    .cw_analog_limit_input(cw_an), .tuning_enable(tun_en), .adaptive_filter_enable(af_en),
    .inertia_estimate_enable(ie_en), .estimate_reset(est_rst), .active_notch_freq(notch),
    .speed_observer_enable(obs_en), .ccw_motion_inhibit(ccw_inh), .cw_motion_inhibit(cw_inh),
    .travel_inhibit_fault(fault), .ccw_limit_out(ccw_lim), .cw_limit_out(cw_lim));
  nv_model nv_model_i (.mclk(mclk), .power_on_pulse(pon), .nv_store_req(st_req),
    .nv_store_data(st), .lat(lat), .nv_load_data(ld), .nv_load_valid(ld_v),
    .nv_store_done(st_done), .saves(saves), .stored(stored));
  // ============================================================
  // shared tasks
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ck(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) req <= '0;
    #1;
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk) req <= '0;
    #1 ck(rdata, e);
  endtask
  // power-up: optional reset, then the power-on pulse and the store reload
  task boot(input logic r);
    @(posedge mclk) reset <= r;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk) pon <= 1'b1;
    @(posedge mclk) pon <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task pulse_seen(output logic s);
    s = 1'b0;
    repeat (4) begin
      if (est_rst === 1'b1) s = 1'b1;
      @(posedge mclk) #1;
    end
  endtask
  // ============================================================
  // scenarios
  task t_lock;
    foreach (fa[i]) if (i < 6) begin
      wr(i < 4 ? 8'h10 + 8'(i * 4) : (i == 4 ? `IDX_INERTIA : `IDX_NOTCH_FREQ), 16'h0055);
      ck(rej, 1'b1);
    end
    rc(`IDX_INERTIA, 16'h0123);
    wr(`IDX_STIFFNESS, 16'h0003);
    ck(rej, 1'b0);
    wr(`IDX_TUNE_MODE, 16'h0008);
    ck(rej, 1'b1);
    wr(`IDX_TUNE_MODE, 16'h0000);
    ck(tun_en, 1'b0);
    wr(`IDX_INERTIA, 16'h0055);
    rc(`IDX_INERTIA, 16'h0055);
    wr(`IDX_TUNE_MODE, 16'h0007);
    ck(tun_en, 1'b1);
    $display("test lock done");
  endtask
  task t_force;
    posc <= 1'b1;
    wr(`IDX_FF_GAIN, 16'h0999);
    wr(`IDX_OBSERVER, 16'h0001);
    foreach (fa[i]) rc(fa[i], fv[i]);
    ck(obs_en, 1'b0);
    rc(`IDX_SW_MODE1, 16'h0000);
    wr(`IDX_TUNE_MODE, 16'h0006);
    rc(`IDX_SW_MODE1, `SW_MODE1_POS);
    posc <= 1'b0;
    rc(`IDX_SW_MODE1, 16'h0000);
    wr(`IDX_TUNE_MODE, 16'h0000);
    wr(`IDX_FF_GAIN, 16'h0999);
    wr(`IDX_OBSERVER, 16'h0001);
    rc(`IDX_FF_GAIN, 16'h0999);
    ck(obs_en, 1'b1);
    rc(`IDX_STATUS, 16'h0004);
    $display("test force done");
  endtask
  task t_filter;
    wr(`IDX_FILT_MODE, 16'h0000);
    ck(af_en, 1'b0);
    wr(`IDX_FILT_MODE, 16'h0001);
    ck(af_en, 1'b1);
    wr(`IDX_NOTCH_FREQ, 16'h0100);
    wr(`IDX_CONTROL_MODE, 16'h0004);
    torq <= 1'b1;
    wr(`IDX_NOTCH_FREQ, 16'h0200);
    ck(notch, 16'h0100);
    ck(af_en, 1'b0);
    torq <= 1'b0;
    @(posedge mclk) #1 ck(notch, 16'h0200);
    $display("test filter done");
  endtask
  task t_reinit;
    logic s;
    // both modes were zero after the force test, so this re-enable resets
    wr(`IDX_TUNE_MODE, 16'h0001);
    pulse_seen(s);
    ck(s, 1'b1);
    wr(`IDX_FILT_MODE, 16'h0000);
    wr(`IDX_TUNE_MODE, 16'h0000);
    wr(`IDX_TUNE_MODE, 16'h0001);
    wr(`IDX_FILT_MODE, 16'h0002);
    pulse_seen(s);
    ck(s, 1'b1);
    // filter mode stays on, so toggling tuning alone must not reset
    wr(`IDX_TUNE_MODE, 16'h0000);
    wr(`IDX_TUNE_MODE, 16'h0001);
    pulse_seen(s);
    ck(s, 1'b0);
    ck(ie_en, 1'b1);
    trial <= 1'b1;
    @(posedge mclk) #1 ck(ie_en, 1'b0);
    trial <= 1'b0;
    $display("test reinit done");
  endtask
  task t_save;
    int n;
    // land the estimate just after a save so no tick catches the old pair
    n = saves;
    for (int c = 0; c < 100 && saves == n; c++) @(posedge mclk);
    @(posedge mclk) est <= {16'h0AA0, 16'h0BB0};
    est_v <= 1'b1;
    @(posedge mclk) est_v <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      n = saves;
      for (int c = 0; c < 100 && saves == n; c++) @(posedge mclk);
      #1 ck(stored, {16'h0AA0, 16'h0BB0});
      ck(16'(saves - n), 16'h0001);
      lat <= 4'h5;
    end
    boot(1'b1);
    rc(`IDX_INERTIA, 16'h0AA0);
    rc(`IDX_NOTCH_FREQ, 16'h0BB0);
    $display("test save done");
  endtask
  task t_travel;
    ccw_sw <= 1'b1;
    wr(`IDX_TRAVEL_INH, 16'h0000);
    ck(ccw_inh, 1'b0);
    boot(1'b0);
    ck(ccw_inh, 1'b1);
    ck(cw_inh, 1'b0);
    ck(fault, 1'b0);
    wr(`IDX_TRAVEL_INH, 16'h0003);
    ck(rej, 1'b1);
    wr(`IDX_TRAVEL_INH, 16'h0002);
    boot(1'b0);
    ck(fault, 1'b1);
    ccw_sw <= 1'b0;
    $display("test travel done");
  endtask
  task t_limit;
    wr(`IDX_LIMIT1, 16'h0111);
    wr(`IDX_LIMIT2, 16'h0222);
    foreach (lt[i]) begin
      gsel <= lt[i][1][0];
      wr(`IDX_TORQUE_SEL, lt[i][0]);
      repeat (2) @(posedge mclk);
      #1 ck(ccw_lim, lt[i][2]);
      ck(cw_lim, lt[i][3]);
    end
    wr(`IDX_TORQUE_SEL, 16'h0004);
    ck(rej, 1'b1);
    $display("test limit done");
  endtask
  // ============================================================
  // main sequence and watchdog
  initial begin
    boot(1'b1);
    rc(`IDX_TUNE_MODE, `TUNE_MODE_RST);
    rc(`IDX_TORQUE_SEL, `TORQUE_SEL_RST);
    rc(`IDX_TRAVEL_INH, `TRAVEL_INH_RST);
    t_lock;
    t_force;
    t_filter;
    t_reinit;
    t_save;
    t_travel;
    t_limit;
    test_done;
  end
  // the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
